/* hw/sesfe_pkg.sv */
// Constants and types shared by the SPI EEPROM serial front end design files.
package sesfe_pkg;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int         ADDR_W      = 11;                       // Byte address width.
	localparam int         PAGE_W      = 5;                        // Offset width inside one page.
	localparam int         PAGE_BYTES  = 32;                       // Bytes in one page.
	localparam int         PAGE_COUNT  = 64;                       // Pages in the array.
	localparam int         ARRAY_BYTES = PAGE_BYTES * PAGE_COUNT;  // Bytes in the array.
	localparam logic [5:0] PAGE_FULL   = 6'h20;                    // Byte count of a full page.
	localparam logic [5:0] CNT_ONE     = 6'h01;                    // Last byte of a page write.

	// ----------------------------------------------------------------
	// Instruction codes (upper nibble zero, bit 3 ignored)
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_HI_ZERO  = 4'h0;  // Required upper nibble.
	localparam logic [2:0] OP_SET_WEL  = 3'h6;  // Latch set.
	localparam logic [2:0] OP_CLR_WEL  = 3'h4;  // Latch reset.
	localparam logic [2:0] OP_STAT_RD  = 3'h5;  // Status read.
	localparam logic [2:0] OP_STAT_WR  = 3'h1;  // Status write.
	localparam logic [2:0] OP_ARR_RD   = 3'h3;  // Array read.
	localparam logic [2:0] OP_ARR_WR   = 3'h2;  // Array write.

	// ----------------------------------------------------------------
	// Status and protection values
	// ----------------------------------------------------------------
	localparam logic [2:0] NV_RESET    = 3'h0;   // Non-volatile bits after reset.
	localparam logic [7:0] STAT_BUSY   = 8'hFF;  // Status byte during a write cycle.
	localparam logic [2:0] SPARE_ZERO  = 3'h0;   // Unused status bits.
	localparam logic [1:0] BP_QUARTER  = 2'h1;   // Top quarter protected.
	localparam logic [1:0] BP_HALF     = 2'h2;   // Top half protected.
	localparam logic [1:0] BP_ALL      = 2'h3;   // Whole array protected.
	localparam logic [1:0] QUARTER_TOP = 2'h3;   // Address bits 10:9 of the top quarter.

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_PERIOD_NS   = 25;                             // System clock period.
	localparam int PROG_TIME_NS    = 5000000;                        // Longest programming time.
	localparam int PROG_CYCLES_DEF = PROG_TIME_NS / SYS_PERIOD_NS;  // Rounded down.
	localparam int WAIT_W          = 18;                             // Width of the cycle timer.

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// Serial link sequence states.
	typedef enum logic [7:0] {
		L_OPC   = 8'h01,
		L_RADDR = 8'h02,
		L_WADDR = 8'h04,
		L_RD    = 8'h08,
		L_WR    = 8'h10,
		L_SRD   = 8'h20,
		L_SWR   = 8'h40,
		L_IGN   = 8'h80
	} sesfe_link_st_t;

	// Internal programming states.
	typedef enum logic [3:0] {
		P_IDLE  = 4'h1,
		P_READ  = 4'h2,
		P_WRITE = 4'h4,
		P_WAIT  = 4'h8
	} sesfe_prog_st_t;

	// Status byte layout.
	typedef struct packed {
		logic       pin_en;  // Protect pin enable.
		logic [2:0] spare;   // Unused, zero when idle.
		logic       bp_hi;   // Block protect high.
		logic       bp_lo;   // Block protect low.
		logic       wel;     // Write enable latch.
		logic       busy;    // Write cycle in progress.
	} sesfe_status_t;

	// Page write request handed from the link to the system side.
	typedef struct packed {
		logic [ADDR_W-1:0] base;  // First byte address.
		logic [5:0]        cnt;   // Bytes received, capped at a page.
	} sesfe_wreq_t;

endpackage : sesfe_pkg

/* hw/sesfe_mem.sv */
// Simple dual-clock memory with a registered read port.
module sesfe_mem #(
	parameter int W  = 8,
	parameter int D  = 32,
	parameter int AW = 5
) (
	input  wire logic          wclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic          rclk,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [W-1:0] cells [D];  // Memory cells, no reset.

	// Write port stores one word per write strobe.
	always_ff @(posedge wclk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
	end

	// Read port registers the addressed word on every rising edge.
	always_ff @(posedge rclk) begin
		rdata <= cells[raddr];
	end

endmodule : sesfe_mem

/* hw/sesfe_top.sv */
// Serial front end of a 16-kbit SPI EEPROM with hold, write protect and timed programming.
import sesfe_pkg::*;

module sesfe_top import sesfe_pkg::*; #(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
	input  wire logic sys_clk,     // System clock, 40 MHz.
	input  wire logic nrst,        // Asynchronous reset, active low.
	input  wire logic sck,         // Serial clock from the master.
	input  wire logic cs_n,        // Chip select, active low.
	input  wire logic sdi,         // Serial data input.
	input  wire logic hold_n,      // Hold, active low.
	input  wire logic wp_n,        // Write protect, active low.
	output logic      so,          // Serial data output value.
	output logic      so_oe_n,     // Serial output enable, low while driving.
	output logic      write_busy   // Internal write cycle in progress.
);

	// ----------------------------------------------------------------
	// Link side declarations
	// ----------------------------------------------------------------
	logic                frame_rst;    // Link reset, active while deselected.
	logic                so_off;       // Output forced off.
	sesfe_link_st_t      state;        // Sequence state.
	sesfe_link_st_t      next_state;   // Next sequence state.
	logic [2:0]          bit_cnt;      // Bits taken in the current byte.
	logic [7:0]          sh;           // Input shift register.
	logic [7:0]          byte_in;      // Byte completed by this edge.
	logic                byte_done;    // Last bit of a byte taken now.
	logic                op_ok;        // Opcode upper nibble is zero.
	logic [2:0]          op;           // Opcode low bits.
	logic                addr_phase;   // Second address byte pending.
	logic [2:0]          addr_hi;      // Upper address bits.
	logic [ADDR_W-1:0]   rd_addr;      // Current read address.
	logic [ADDR_W-1:0]   next_rd_addr; // Read address after this edge.
	logic                fresh;        // No edge yet in this frame.
	logic                frame_tog;    // Toggles once per clocked frame.
	logic                wr_req;       // Frame holds array write data.
	logic                st_req;       // Frame holds a status write.
	logic                ws_req;       // Frame set the write latch.
	logic                wc_req;       // Frame cleared the write latch.
	sesfe_wreq_t         wreq;         // Page write base and count.
	logic [7:0]          st_val;       // Status write value.
	logic                buf_we;       // Page buffer write strobe.
	logic [PAGE_W-1:0]   buf_waddr;    // Page buffer write offset.
	logic [7:0]          arr_rdata;    // Array read data.
	sesfe_status_t       stat_l1;      // Status, first sync stage.
	sesfe_status_t       stat_l;       // Status in the link domain.
	logic [7:0]          src_byte;     // Byte being shifted out.
	logic                out_state;    // Sequence drives the output.

	// ----------------------------------------------------------------
	// System side declarations
	// ----------------------------------------------------------------
	sesfe_prog_st_t      pst;          // Programming state.
	sesfe_prog_st_t      next_pst;     // Next programming state.
	logic [2:0]          cs_s;         // Chip select sync and history.
	logic [1:0]          wp_s;         // Write protect sync.
	logic [4:0]          req_s1;       // Request flags, first stage.
	logic [4:0]          req_s2;       // Request flags, second stage.
	logic                tog_seen;     // Last frame toggle handled.
	logic                commit;       // Valid deselect of a new frame.
	logic                pin_en;       // Protect pin enable bit.
	logic                bp_hi;        // Block protect high bit.
	logic                bp_lo;        // Block protect low bit.
	logic                wel;          // Write enable latch.
	logic                hw_protect;   // Status writes blocked by the pin.
	logic                st_go;        // Accepted status write.
	logic                wr_go;        // Accepted array write.
	logic [PAGE_W-1:0]   off;          // Page offset being programmed.
	logic [5:0]          left;         // Bytes left to program.
	logic [5:0]          page;         // Page being programmed.
	logic [WAIT_W-1:0]   wait_cnt;     // Programming timer.
	logic                wait_end;     // Timer reaches its last cycle.
	logic [7:0]          buf_rdata;    // Page buffer read data.
	logic [ADDR_W-1:0]   prog_addr;    // Array address being programmed.
	logic                blocked;      // Address lies in a protected block.
	logic                arr_we;       // Array write strobe.

	// ----------------------------------------------------------------
	// Link decode
	// ----------------------------------------------------------------
	assign frame_rst = !nrst || cs_n;
	assign so_off    = frame_rst || !hold_n;
	assign byte_in   = {sh[6:0], sdi};
	assign byte_done = hold_n && (bit_cnt == 3'h7);
	assign op_ok     = (byte_in[7:4] == OP_HI_ZERO);
	assign op        = byte_in[2:0];
	assign buf_we    = (state == L_WR) && byte_done;
	assign buf_waddr = wreq.base[PAGE_W-1:0] + wreq.cnt[PAGE_W-1:0];
	assign out_state = (state == L_RD) || (state == L_SRD);
	assign src_byte  = (state == L_SRD) ? (stat_l.busy ? STAT_BUSY : stat_l) : arr_rdata;
	assign next_rd_addr = ((state == L_RADDR) && byte_done && addr_phase) ? {addr_hi, byte_in} :
	                      ((state == L_RD) && byte_done) ? rd_addr + 11'h001 : rd_addr;

	// Sequence decode: opcode, then address, then data; busy admits status read only.
	always_comb begin
		next_state = state;
		case (state)
			L_OPC: begin
				if (byte_done) begin
					if (!op_ok) begin
						next_state = L_IGN;
					end else if (op == OP_STAT_RD) begin
						next_state = L_SRD;
					end else if (stat_l.busy) begin
						next_state = L_IGN;
					end else if (op == OP_STAT_WR) begin
						next_state = L_SWR;
					end else if (op == OP_ARR_RD) begin
						next_state = L_RADDR;
					end else if (op == OP_ARR_WR) begin
						next_state = L_WADDR;
					end else begin
						next_state = L_IGN;
					end
				end
			end
			L_RADDR: begin
				if (byte_done && addr_phase) begin
					next_state = L_RD;
				end
			end
			L_WADDR: begin
				if (byte_done && addr_phase) begin
					next_state = L_WR;
				end
			end
			L_SWR: begin
				if (byte_done) begin
					next_state = L_IGN;
				end
			end
			L_RD, L_WR, L_SRD, L_IGN: begin
				next_state = state;
			end
			default: begin
				next_state = L_IGN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Link logic on rising and falling serial clock edges
	// ----------------------------------------------------------------
	// Shifts one bit per rising edge; hold freezes everything; deselect restarts.
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			state      <= L_OPC;
			bit_cnt    <= 3'h0;
			sh         <= 8'h00;
			addr_phase <= 1'b0;
			addr_hi    <= 3'h0;
			rd_addr    <= 11'h000;
			fresh      <= 1'b1;
		end else if (hold_n) begin
			state      <= next_state;
			bit_cnt    <= bit_cnt + 3'h1;
			sh         <= byte_in;
			rd_addr    <= next_rd_addr;
			fresh      <= 1'b0;
			if (byte_done && ((state == L_RADDR) || (state == L_WADDR))) begin
				addr_phase <= !addr_phase;
				addr_hi    <= byte_in[2:0];
			end
		end
	end

	// Frame requests survive deselect so the system side can act on them.
	always_ff @(posedge sck or negedge nrst) begin
		if (!nrst) begin
			frame_tog <= 1'b0;
			{wr_req, st_req, ws_req, wc_req} <= 4'h0;
			wreq      <= '0;
			st_val    <= 8'h00;
		end else if (!cs_n && hold_n) begin
			if (fresh) begin
				frame_tog <= !frame_tog;
				{wr_req, st_req, ws_req, wc_req} <= 4'h0;
				wreq.cnt  <= 6'h00;
			end
			if ((state == L_OPC) && byte_done && op_ok && !stat_l.busy) begin
				ws_req <= (op == OP_SET_WEL);
				wc_req <= (op == OP_CLR_WEL);
			end
			if ((state == L_WADDR) && byte_done && addr_phase) begin
				wreq.base <= {addr_hi, byte_in};
			end
			if (buf_we) begin
				wr_req   <= 1'b1;
				wreq.cnt <= (wreq.cnt == PAGE_FULL) ? PAGE_FULL : wreq.cnt + 6'h01;
			end
			if ((state == L_SWR) && byte_done) begin
				st_req <= 1'b1;
				st_val <= byte_in;
			end
		end
	end

	// Status crosses as a slowly changing level through two flops.
	always_ff @(posedge sck or negedge nrst) begin
		if (!nrst) begin
			stat_l1 <= '0;
			stat_l  <= '0;
		end else begin
			stat_l1 <= {pin_en, SPARE_ZERO, bp_hi, bp_lo, wel, write_busy};
			stat_l  <= stat_l1;
		end
	end

	// Output updates on falling edges; modes 0 and 3 both start with the output off.
	always_ff @(negedge sck or posedge so_off) begin
		if (so_off) begin
			so_oe_n <= 1'b1;
			so      <= 1'b0;
		end else begin
			so_oe_n <= !out_state;
			so      <= src_byte[3'h7 - bit_cnt];
		end
	end

	// ----------------------------------------------------------------
	// Memories
	// ----------------------------------------------------------------
	sesfe_mem #(.W(8), .D(PAGE_BYTES), .AW(PAGE_W)) u_page_buf (
		.wclk  (sck),
		.we    (buf_we),
		.waddr (buf_waddr),
		.wdata (byte_in),
		.rclk  (sys_clk),
		.raddr (off),
		.rdata (buf_rdata)
	);

	sesfe_mem #(.W(8), .D(ARRAY_BYTES), .AW(ADDR_W)) u_array (
		.wclk  (sys_clk),
		.we    (arr_we),
		.waddr (prog_addr),
		.wdata (buf_rdata),
		.rclk  (sck),
		.raddr (next_rd_addr),
		.rdata (arr_rdata)
	);

	// ----------------------------------------------------------------
	// System side decode
	// ----------------------------------------------------------------
	assign commit     = cs_s[1] && !cs_s[2] && (req_s2[4] != tog_seen) && (pst == P_IDLE);
	assign hw_protect = pin_en && !wp_s[1];
	assign st_go      = commit && req_s2[2] && wel && !hw_protect;
	assign wr_go      = commit && req_s2[3] && wel;
	assign prog_addr  = {page, off};
	assign blocked    = ({bp_hi, bp_lo} == BP_ALL) ||
	                    (({bp_hi, bp_lo} == BP_HALF) && prog_addr[10]) ||
	                    (({bp_hi, bp_lo} == BP_QUARTER) && (prog_addr[10:9] == QUARTER_TOP));
	assign arr_we     = (pst == P_WRITE) && !blocked;
	assign wait_end   = (wait_cnt == WAIT_W'(PROG_CYCLES - 1));

	// Programming sequence: copy buffered bytes, then run the timed cycle.
	always_comb begin
		next_pst = pst;
		case (pst)
			P_IDLE: begin
				if (wr_go) begin
					next_pst = P_READ;
				end else if (st_go) begin
					next_pst = P_WAIT;
				end
			end
			P_READ: begin
				next_pst = P_WRITE;
			end
			P_WRITE: begin
				next_pst = (left == CNT_ONE) ? P_WAIT : P_READ;
			end
			P_WAIT: begin
				next_pst = wait_end ? P_IDLE : P_WAIT;
			end
			default: begin
				next_pst = P_IDLE;
			end
		endcase
	end

	// Pin synchronisers and request flags, two flops each; chip select has a third flop for edge history.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cs_s   <= 3'h7;
			wp_s   <= 2'h3;
			req_s1 <= 5'h00;
			req_s2 <= 5'h00;
		end else begin
			cs_s   <= {cs_s[1:0], cs_n};
			wp_s   <= {wp_s[0], wp_n};
			req_s1 <= {frame_tog, wr_req, st_req, ws_req, wc_req};
			req_s2 <= req_s1;
		end
	end

	// Status bits, write latch and programming counters.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pst        <= P_IDLE;
			{pin_en, bp_hi, bp_lo} <= NV_RESET;
			wel        <= 1'b0;
			write_busy <= 1'b0;
			tog_seen   <= 1'b0;
			off        <= 5'h00;
			left       <= 6'h00;
			page       <= 6'h00;
			wait_cnt   <= '0;
		end else begin
			pst        <= next_pst;
			write_busy <= (next_pst != P_IDLE);
			wait_cnt   <= (pst == P_WAIT) ? wait_cnt + 18'h00001 : '0;
			if (cs_s[1] && !cs_s[2]) begin
				tog_seen <= req_s2[4];
			end
			if (commit && req_s2[0]) begin
				wel <= 1'b0;
			end else if (commit && req_s2[1]) begin
				wel <= 1'b1;
			end else if ((pst == P_WAIT) && wait_end) begin
				wel <= 1'b0;
			end
			if (st_go) begin
				pin_en <= st_val[7];
				bp_hi  <= st_val[3];
				bp_lo  <= st_val[2];
			end
			if (wr_go) begin
				off  <= wreq.base[PAGE_W-1:0];
				page <= wreq.base[ADDR_W-1:PAGE_W];
				left <= wreq.cnt;
			end else if (pst == P_WRITE) begin
				off  <= off + 5'h01;
				left <= left - 6'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	deselect_hiz_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(cs_n && $past(cs_n)) |-> so_oe_n) else $error("Output driven while deselected.");
	hold_hiz_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!hold_n && $past(!hold_n)) |-> so_oe_n) else $error("Output driven during hold.");
	hold_freeze_a: assert property (@(posedge sck) disable iff (frame_rst)
		!hold_n |=> ($stable(bit_cnt) && $stable(state))) else $error("Sequence moved in hold.");
	bit_count_a: assert property (@(posedge sck) disable iff (frame_rst)
		hold_n |=> (bit_cnt == $past(bit_cnt) + 3'h1)) else $error("Bit count did not advance.");
	opcode_decode_a: assert property (@(posedge sck) disable iff (frame_rst)
		((state == L_OPC) && byte_done && op_ok && (op == OP_STAT_RD)) |=> (state == L_SRD))
		else $error("Status read opcode not decoded.");
	read_bit_a: assert property (@(posedge sck) disable iff (frame_rst)
		(hold_n && !so_oe_n && (state == L_RD)) |-> (so == arr_rdata[3'h7 - bit_cnt]))
		else $error("Read bit out of order.");
	pin_refuse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(commit && req_s2[2] && pin_en && !wp_s[1]) |=> ($stable(pin_en) && $stable(bp_hi) && $stable(bp_lo)))
		else $error("Status changed under pin protection.");
	status_accept_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(commit && req_s2[2] && wel && (!pin_en || wp_s[1])) |=> ((pin_en == $past(st_val[7])) && write_busy))
		else $error("Status write refused.");
	cycle_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(pst == P_WAIT) |-> (wait_cnt < WAIT_W'(PROG_CYCLES))) else $error("Write cycle overran.");
	cycle_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		((pst == P_WAIT) && !wait_end) |=> ((pst == P_WAIT) && write_busy))
		else $error("Write cycle cut short.");

endmodule : sesfe_top

/* verif/sesfe_spi_master.sv */
// Behavioural SPI master that drives the serial side of the front end.
module sesfe_spi_master (
	output logic      sck,     // Serial clock, still outside frames.
	output logic      cs_n,    // Chip select, active low.
	output logic      sdi,     // Serial data to the device.
	output logic      hold_n,  // Hold, active low.
	input  wire logic so,      // Device output value.
	input  wire logic so_oe_n  // Device output enable, low while driving.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic idle    = 1'b0;  // Clock idle level, 0 for mode 0, 1 for mode 3.
	logic held_oe = 1'b0;  // Output enable seen while paused.
	wire  line    = so_oe_n ? ~so : so;  // A released line floats away.
	initial begin
		sck <= 1'b0;
		cs_n <= 1'b1;
		sdi <= 1'b0;
		hold_n <= 1'b1;
	end
	// Runs one frame of n bytes, pausing before bit hold_at.
	task automatic frame(input logic [63:0] tx, input int n, input int hold_at, output logic [63:0] rx);
		rx = '0;
		sck <= idle;
		#24 cs_n <= 1'b0;
		#24;
		for (int i = 0; i < 8 * n; i++) begin
			sck <= 1'b0;
			sdi <= tx[63 - i];
			if (i == hold_at) begin
				#12 hold_n <= 1'b0;
				repeat (3) begin
					#24 sck <= 1'b1;
					sdi <= ~tx[63 - i];
					held_oe = so_oe_n;
					#24 sck <= 1'b0;
				end
				sdi <= tx[63 - i];
				#12 hold_n <= 1'b1;
			end
			#24 sck <= 1'b1;
			rx = {rx[62:0], line};
			#24;
		end
		sck <= idle;
		#12 cs_n <= 1'b1;
		#200;
	endtask : frame
endmodule : sesfe_spi_master

/* verif/tb_spi_eeprom_serial_front_end.sv */
// Self-checking bench for the serial front end.
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb_spi_eeprom_serial_front_end import sesfe_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk, nrst, wp_n;  // System side inputs.
	logic        sck, cs_n, sdi, hold_n, so, so_oe_n, write_busy;
	logic [63:0] rx;                   // Bytes seen in a frame.
	int          err_total = 0;
	int          checks_done = 0;
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	sesfe_top #(.PROG_CYCLES(200)) dut (.sys_clk(sys_clk), .nrst(nrst), .sck(sck), .cs_n(cs_n),
		.sdi(sdi), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .write_busy(write_busy));
	sesfe_spi_master m (.sck(sck), .cs_n(cs_n), .sdi(sdi), .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n));
	task automatic tally_and_finish();
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// Waits for the programming cycle to end within a bound.
	task automatic idle_wait();
		int n = 0;
		repeat (10) @(posedge sys_clk);
		while (write_busy !== 1'b0 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK("busy end", 1'b0, write_busy)
	endtask : idle_wait
	task automatic stat(input logic [7:0] ex);
		logic [63:0] r;
		m.frame({8'h05, 56'h0}, 2, -1, r);
		`CHK("status", ex, r[7:0])
	endtask : stat
	// Sets the latch, writes status, optionally drops the protect pin mid-cycle.
	task automatic swr(input logic [7:0] v, input bit drop);
		logic [63:0] r;
		m.frame({8'h06, 56'h0}, 1, -1, r);
		m.frame({8'h01, v, 48'h0}, 2, -1, r);
		if (drop) @(posedge sys_clk) wp_n <= 1'b0;
		idle_wait();
	endtask : swr
	initial begin
		#500us;
		err_total++;
		tally_and_finish();
	end
	initial begin
		nrst = 1'b0;
		wp_n = 1'b1;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		`CHK("oe idle", 1'b1, so_oe_n)
		stat(8'h00);
		m.frame({8'h0E, 56'h0}, 1, -1, rx);
		stat(8'h02);
		m.frame({8'h04, 56'h0}, 1, -1, rx);
		stat(8'h00);
		m.frame({8'h16, 56'h0}, 1, -1, rx);
		stat(8'h00);
		m.frame({8'h06, 56'h0}, 1, -1, rx);
		m.frame({8'h02, 16'h07FE, 16'hA53C, 24'h0}, 5, -1, rx);
		repeat (12) @(posedge sys_clk);
		`CHK("busy", 1'b1, write_busy)
		stat(STAT_BUSY);
		idle_wait();
		m.frame({8'h03, 16'h07FE, 40'h0}, 5, 12, rx);
		`CHK("read", 16'hA53C, rx[15:0])
		`CHK("hold oe", 1'b1, m.held_oe)
		m.idle = 1'b1;
		stat(8'h00);
		m.idle = 1'b0;
		swr(8'h80, 0);
		stat(8'h80);
		@(posedge sys_clk) wp_n <= 1'b0;
		swr(8'h00, 0);
		stat(8'h82);
		@(posedge sys_clk) wp_n <= 1'b1;
		swr(8'h00, 0);
		@(posedge sys_clk) wp_n <= 1'b0;
		swr(8'h0C, 0);
		stat(8'h0C);
		@(posedge sys_clk) wp_n <= 1'b1;
		swr(8'h8C, 1);
		stat(8'h8C);
		m.frame({8'h06, 56'h0}, 1, -1, rx);
		m.frame({8'h02, 16'h07FE, 16'h5AC3, 24'h0}, 5, -1, rx);
		idle_wait();
		m.frame({8'h03, 16'h07FE, 40'h0}, 5, -1, rx);
		`CHK("protected", 16'hA53C, rx[15:0])
		tally_and_finish();
	end
endmodule : tb_spi_eeprom_serial_front_end
